// file: dv/tb_top.sv
// self-checking bench for the auto-baud detector and baud generator
// assumes the remote model drives RX and software pulses are one cycle wide
`timescale 1ns/1ps
module tb_top;
   import uabd_pkg::*;
   // =====================================================================
   // signals
   logic        clk = 1'b0;      // core clock, 25 ns period
   logic        rst = 1'b1;      // async reset, high
   logic        sync_mode = 1'b0;
   logic        wide = 1'b0;
   logic        fast = 1'b0;
   logic        wake = 1'b0;
   logic [6:0]  pls = '0;        // set, clr, ovf set, ovf clr, div wr, read, frame done
   logic [15:0] wdata = 16'h0000;
   logic        ce = 1'b1;       // clock enable, low freezes the block
   logic        rx;              // driven by remote model
   logic        en, ovf, cflag, hold, blocked, btick, stick;
   logic [7:0]  div_lo, div_hi;
   int          failures = 0;
   int          comparisons = 0;

   always #12.5 clk = ~clk;

   // =====================================================================
   // instances
   uabd_remote remote (.clk(clk), .rx(rx));
   uabd_top uut (
      .CORE_CLK(clk), .RST(rst), .CLK_EN(ce), .RX(rx), .SYNC_MODE(sync_mode),
      .WIDE_DIVISOR_SELECT(wide), .HIGH_SPEED_SELECT(fast),
      .WAKE_ON_BREAK_ENABLE(wake), .AUTO_BAUD_ENABLE_SET(pls[0]),
      .AUTO_BAUD_ENABLE_CLR(pls[1]), .OVERFLOW_FLAG_SET(pls[2]),
      .OVERFLOW_FLAG_CLR(pls[3]), .DIVISOR_WRITE(pls[4]), .DIVISOR_WDATA(wdata),
      .RECEIVE_DATA_READ(pls[5]), .RECEIVE_FRAME_DONE(pls[6]),
      // software never writes the transmit buffer in this bench
      .TRANSMIT_BUFFER_WRITE(1'b0), .AUTO_BAUD_ENABLE(en),
      .AUTO_BAUD_OVERFLOW_FLAG(ovf), .BAUD_DIVISOR_LOW(div_lo),
      .BAUD_DIVISOR_HIGH(div_hi), .RECEIVE_COMPLETE_FLAG(cflag),
      .RECEIVER_HOLD_IDLE(hold), .TRANSMIT_BLOCKED(blocked),
      .BIT_TICK(btick), .SAMPLE_TICK(stick));

   // =====================================================================
   // shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one-cycle software pulse on bit i, launched and dropped at rising edges
   task automatic pulse(input int i);
      @(posedge clk);
      pls[i] <= 1'b1;
      @(posedge clk);
      pls[i] <= 1'b0;
   endtask : pulse

   // wait past two edges so registered answers have landed
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle

   task automatic tally_and_finish();
      if (failures == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // =====================================================================
   // scenarios
   task automatic t_arm();
      check("reset enable", {15'h0, en}, 16'h0000);
      check("reset divisor", {div_hi, div_lo}, 16'h0000);
      wdata <= 16'h1234;
      pulse(4);
      settle();
      check("divisor load", {div_hi, div_lo}, 16'h1234);
      pulse(0);
      settle();
      check("enable set", {15'h0, en}, 16'h0001);
      check("tx blocked", {15'h0, blocked}, 16'h0001);
      check("rx held", {15'h0, hold}, 16'h0001);
      check("divisor cleared", {div_hi, div_lo}, 16'h0000);
      wdata <= 16'hABCD;
      pulse(4);
      settle();
      check("write refused", {div_hi, div_lo}, 16'h0000);
      pulse(1);
      settle();
      check("enable cleared", {15'h0, en}, 16'h0001 ^ 16'h0001);
   endtask : t_arm

   // expected count is bit period over prescale, one tick of phase slack
   task automatic t_measure(input logic w, input logic f, input int bp, input int exp);
      logic [15:0] cnt;
      wide <= w;
      fast <= f;
      pulse(0);
      settle();
      remote.send_55(bp);
      settle();
      cnt = {div_hi, div_lo};
      check("count in range", {15'h0, (cnt >= exp - 1 && cnt <= exp + 1)}, 16'h0001);
      check("high byte zero", {8'h00, div_hi}, 16'h0000);
      check("enable auto clear", {15'h0, en}, 16'h0000);
      check("complete flag", {15'h0, cflag}, 16'h0001);
      pulse(5);
      settle();
      check("flag cleared", {15'h0, cflag}, 16'h0000);
   endtask : t_measure

   task automatic t_wake();
      wake <= 1'b1;
      wide <= 1'b1;
      fast <= 1'b1;
      pulse(0);
      settle();
      remote.send_break(4000, 640);
      check("still armed", {15'h0, en}, 16'h0001);
      remote.send_55(320);
      settle();
      check("wake count", {div_hi, div_lo} - 16'h0009 <= 16'h0002, 16'h0001);
      wake <= 1'b0;
      pulse(5);
   endtask : t_wake

   task automatic t_sync();
      sync_mode <= 1'b1;
      pulse(0);
      settle();
      remote.send_55(320);
      settle();
      check("sync stays idle", {15'h0, hold}, 16'h0000);
      check("sync no flag", {15'h0, cflag}, 16'h0000);
      pulse(1);
      sync_mode <= 1'b0;
   endtask : t_sync

   task automatic t_flags();
      pulse(2);
      settle();
      check("ovf set", {15'h0, ovf}, 16'h0001);
      pulse(3);
      settle();
      check("ovf clear", {15'h0, ovf}, 16'h0000);
      pulse(6);
      settle();
      check("frame flag", {15'h0, cflag}, 16'h0001);
      pulse(5);
      settle();
      check("frame flag read", {15'h0, cflag}, 16'h0000);
   endtask : t_flags

   // gap between two bit ticks, bounded waits
   task automatic t_tick(input logic w, input logic f, input int exp);
      int n;
      int s;
      wide <= w;
      fast <= f;
      wdata <= 16'h0009;
      pulse(4);
      settle();
      n = 0;
      while (btick !== 1'b1 && n < 5000) begin
         @(posedge clk);
         #1;
         n++;
      end
      n = 0;
      s = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (stick === 1'b1) s++;
      end while (btick !== 1'b1 && n < 5000);
      check("bit tick gap", 16'(n), 16'(exp));
      // divisor 9 gives a sample tick every ten cycles
      check("sample ticks per bit", 16'(s), 16'(exp / 10));
   endtask : t_tick

   // low clock enable must freeze every state change
   task automatic t_freeze();
      ce <= 1'b0;
      pulse(0);
      settle();
      check("frozen enable", {15'h0, en}, 16'h0000);
      pulse(2);
      settle();
      check("frozen ovf", {15'h0, ovf}, 16'h0000);
      ce <= 1'b1;
   endtask : t_freeze

   // =====================================================================
   // main sequence and watchdog
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      settle();
      t_arm();
      t_measure(1'b1, 1'b1, 320, 10);
      t_measure(1'b1, 1'b0, 1280, 10);
      t_measure(1'b0, 1'b1, 1280, 10);
      t_measure(1'b0, 1'b0, 2048, 4);
      t_wake();
      t_sync();
      t_flags();
      t_tick(1'b1, 1'b1, 40);
      t_tick(1'b1, 1'b0, 160);
      t_freeze();
      tally_and_finish();
   end

   initial begin
      #2400us;
      failures++;
      tally_and_finish();
   end
endmodule : tb_top

// file: dv/uabd_remote.sv
// remote serial node model that drives the receive line of the auto-baud block
// assumes callers enter its tasks just after a rising edge of clk
`timescale 1ns/1ps
module uabd_remote (
   input  wire logic clk,
   output logic      rx
);
   // =====================================================================
   // line state
   // idle level of an asynchronous line is high between frames
   initial rx = 1'b1;

   // =====================================================================
   // frame sender
   // bp is the bit period in core cycles; the caller picks it
   task automatic send_55(input int bp);
      logic [9:0] frame;
      frame = {1'b1, 8'h55, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx <= frame[i];
         repeat (bp) @(posedge clk);
      end
   endtask : send_55

   // =====================================================================
   // break sender
   // long low then an idle gap, so the rise ending it is not a start bit
   task automatic send_break(input int low_cycles, input int gap_cycles);
      rx <= 1'b0;
      repeat (low_cycles) @(posedge clk);
      rx <= 1'b1;
      repeat (gap_cycles) @(posedge clk);
   endtask : send_break
endmodule : uabd_remote

// file: src/uabd_baudgen.sv
// baud generator: divisor reload counter giving x4, x16 or x64 ticks
// assumes divisor and selects are stable while running
`timescale 1ns/1ps
`include "uabd_defines.svh"
module uabd_baudgen
   import uabd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        run,
   input  wire logic        sync_mode,
   input  wire logic        wide,
   input  wire logic        fast,
   input  wire logic [15:0] divisor,
   output logic             bit_tick,
   output logic             sample_tick
);
   // =====================================================================
   // divisor counter and oversample stage
   logic [15:0] cnt;   // divisor down counter
   logic [5:0]  os;    // oversample counter
   logic [5:0]  os_max;// oversample terminal
   logic [15:0] dv;    // effective divisor
   always_comb begin
      if ((wide && fast) || (sync_mode && wide)) os_max = 6'h03;
      else if (fast || wide)                     os_max = 6'h0F;
      else                                       os_max = 6'h3F;
      dv = wide ? divisor : {8'h00, divisor[7:0]};
   end
   // four, sixteen or sixty-four ticks per bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt         <= 16'h0000;
         os          <= 6'h00;
         sample_tick <= 1'b0;
         bit_tick    <= 1'b0;
      end else if (ce) begin
         sample_tick <= 1'b0;
         bit_tick    <= 1'b0;
         if (!run) begin
            cnt <= dv;
            os  <= 6'h00;
         end else if (cnt == 16'h0000) begin
            cnt         <= dv;
            sample_tick <= 1'b1;
            os          <= (os >= os_max) ? 6'h00 : os + 6'h01;
            bit_tick    <= (os >= os_max);
         end else begin
            cnt <= cnt - 16'h0001;
         end
      end
   end
endmodule : uabd_baudgen

// file: src/uabd_defines.svh
// timing constants and reset values of the baud generator and auto-baud block
// assumes inclusion by every design module that needs them
`ifndef UABD_DEFINES_SVH
`define UABD_DEFINES_SVH
// =====================================================================
// clock
`define UABD_CLK_PERIOD_NS     25
// =====================================================================
// prescale divides for the measuring counter clock (oscillator cycles)
`define UABD_PRE_SLOW          512
`define UABD_PRE_MID           128
`define UABD_PRE_FAST          32
// the measurement runs at one eighth of the bit-clock, so the tick is /8
`define UABD_MEAS_DIV          8
// rising edges that close a measurement (start bit edge counts as first)
`define UABD_EDGE_LAST         3'h5
// =====================================================================
// reset values
`define UABD_DIV_RESET         16'h0000
`endif

// file: src/uabd_pkg.sv
// types shared by the auto-baud block and its helpers
// assumes the defines header is compiled alongside
package uabd_pkg;
   // =====================================================================
   // detector sequence, gray coded along idle, arm, count, with break as the fourth code
   typedef enum logic [1:0] {
      UABD_IDLE  = 2'b00,
      UABD_ARM   = 2'b01,
      UABD_COUNT = 2'b11,
      UABD_BREAK = 2'b10
   } uabd_state_t;
endpackage : uabd_pkg

// file: src/uabd_prescale.sv
// prescaler that turns the oscillator into measuring counter ticks
// assumes the enable input gates every state change
`timescale 1ns/1ps
`include "uabd_defines.svh"
module uabd_prescale
   import uabd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        wide,
   input  wire logic        fast,
   output logic             meas_tick
);
   // =====================================================================
   // free running divider
   logic [8:0] cnt;  // prescale counter
   logic [8:0] lim;  // terminal count
   always_comb begin
      if (wide && fast)       lim = 9'(`UABD_PRE_FAST - 1);
      else if (wide || fast)  lim = 9'(`UABD_PRE_MID - 1);
      else                    lim = 9'(`UABD_PRE_SLOW - 1);
   end
   // restart on wrap or on a shorter limit, so a mode change never stalls
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt       <= 9'h000;
         meas_tick <= 1'b0;
      end else if (ce) begin
         meas_tick <= (cnt >= lim);
         cnt       <= (cnt >= lim) ? 9'h000 : cnt + 9'h001;
      end
   end
endmodule : uabd_prescale

// file: src/uabd_top.sv
// auto-baud detector with its baud generator for an asynchronous serial port
// assumes RX is synchronous to CORE_CLK and software obeys the tx ban
`timescale 1ns/1ps
`include "uabd_defines.svh"
module uabd_top
   import uabd_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic        CLK_EN,
   input  wire logic        RX,
   input  wire logic        SYNC_MODE,
   input  wire logic        WIDE_DIVISOR_SELECT,
   input  wire logic        HIGH_SPEED_SELECT,
   input  wire logic        WAKE_ON_BREAK_ENABLE,
   input  wire logic        AUTO_BAUD_ENABLE_SET,
   input  wire logic        AUTO_BAUD_ENABLE_CLR,
   input  wire logic        OVERFLOW_FLAG_SET,
   input  wire logic        OVERFLOW_FLAG_CLR,
   input  wire logic        DIVISOR_WRITE,
   input  wire logic [15:0] DIVISOR_WDATA,
   input  wire logic        RECEIVE_DATA_READ,
   input  wire logic        RECEIVE_FRAME_DONE,
   input  wire logic        TRANSMIT_BUFFER_WRITE,
   output logic             AUTO_BAUD_ENABLE,
   output logic             AUTO_BAUD_OVERFLOW_FLAG,
   output logic [7:0]       BAUD_DIVISOR_LOW,
   output logic [7:0]       BAUD_DIVISOR_HIGH,
   output logic             RECEIVE_COMPLETE_FLAG,
   output logic             RECEIVER_HOLD_IDLE,
   output logic             TRANSMIT_BLOCKED,
   output logic             BIT_TICK,
   output logic             SAMPLE_TICK
);
   // =====================================================================
   // state
   uabd_state_t state;      // detector sequence
   logic        rx_q;       // previous receive level
   logic [2:0]  edges;      // rising edges seen
   logic [2:0]  sub;        // eighth-rate divider
   logic [15:0] div;        // generator register pair
   logic        meas_tick;  // prescaled counter clock
   logic        rise;       // rising edge of RX
   logic        fall;       // falling edge of RX
   logic        armed_ok;   // detection allowed now
   logic        step;       // counter increment this cycle

   assign rise = RX & ~rx_q;
   assign fall = ~RX & rx_q;
   // async only, break wait handles wake case
   assign armed_ok = ~SYNC_MODE & AUTO_BAUD_ENABLE;
   assign step = (state == UABD_COUNT) && meas_tick && (sub == 3'h7);
   assign BAUD_DIVISOR_LOW  = div[7:0];
   assign BAUD_DIVISOR_HIGH = div[15:8];
   assign RECEIVER_HOLD_IDLE = (state != UABD_IDLE);
   assign TRANSMIT_BLOCKED = AUTO_BAUD_ENABLE;

   // =====================================================================
   // helpers
   uabd_prescale u_pre (
      .clk       (CORE_CLK),
      .rst       (RST),
      .ce        (CLK_EN),
      .wide      (WIDE_DIVISOR_SELECT),
      .fast      (HIGH_SPEED_SELECT),
      .meas_tick (meas_tick)
   );
   // frame timing for the shared shifters
   uabd_baudgen u_gen (
      .clk         (CORE_CLK),
      .rst         (RST),
      .ce          (CLK_EN),
      .run         (~AUTO_BAUD_ENABLE & ~SYNC_MODE | SYNC_MODE),
      .sync_mode   (SYNC_MODE),
      .wide        (WIDE_DIVISOR_SELECT),
      .fast        (HIGH_SPEED_SELECT),
      .divisor     (div),
      .bit_tick    (BIT_TICK),
      .sample_tick (SAMPLE_TICK)
   );

   // =====================================================================
   // receive line history
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST)         rx_q <= 1'b1;
      else if (CLK_EN) rx_q <= RX;
   end

   // =====================================================================
   // detector sequence
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state <= UABD_IDLE;
         edges <= 3'h0;
      end else if (CLK_EN) begin
         unique case (state)
            UABD_IDLE: begin
               // wait out the break when wake is on
               if (armed_ok && WAKE_ON_BREAK_ENABLE) state <= UABD_BREAK;
               else if (armed_ok)                    state <= UABD_ARM;
            end
            UABD_BREAK: begin
               if (!armed_ok)  state <= UABD_IDLE;
               else if (rise)  state <= UABD_ARM;
            end
            UABD_ARM: begin
               edges <= 3'h0;
               // start bit, count from first rise
               if (!armed_ok)  state <= UABD_IDLE;
               else if (rise && !RX == 1'b0 && rx_q == 1'b0) begin
                  state <= UABD_COUNT;
                  edges <= 3'h1;
               end
            end
            UABD_COUNT: begin
               if (!armed_ok) begin
                  state <= UABD_IDLE;
               end else if (rise) begin
                  edges <= edges + 3'h1;
                  if (edges == `UABD_EDGE_LAST - 3'h1) state <= UABD_IDLE;
               end
            end
         endcase
      end
   end

   // =====================================================================
   // eighth-rate divider
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST)                                     sub <= 3'h0;
      else if (CLK_EN && state != UABD_COUNT)      sub <= 3'h0;
      else if (CLK_EN && meas_tick)                sub <= sub + 3'h1;
   end

   // =====================================================================
   // generator register pair, reused as measuring counter
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         div <= `UABD_DIV_RESET;
      end else if (CLK_EN) begin
         if (state == UABD_IDLE && armed_ok) div <= 16'h0000;
         // full 16-bit count regardless of width
         else if (step)                      div <= div + 16'h0001;
         else if (DIVISOR_WRITE && !AUTO_BAUD_ENABLE) div <= DIVISOR_WDATA;
      end
   end

   // =====================================================================
   // enable bit: software sets, hardware clears at completion
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         AUTO_BAUD_ENABLE <= 1'b0;
      end else if (CLK_EN) begin
         // hardware clears it only at the fifth edge, not on rollover
         if (state == UABD_COUNT && rise && edges == `UABD_EDGE_LAST - 3'h1)
            AUTO_BAUD_ENABLE <= 1'b0;
         else if (AUTO_BAUD_ENABLE_SET)
            AUTO_BAUD_ENABLE <= 1'b1;
         else if (AUTO_BAUD_ENABLE_CLR)
            AUTO_BAUD_ENABLE <= 1'b0;
      end
   end

   // =====================================================================
   // overflow flag, hardware set wins over software clear
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         AUTO_BAUD_OVERFLOW_FLAG <= 1'b0;
      end else if (CLK_EN) begin
         if ((step && div == 16'hFFFF) || OVERFLOW_FLAG_SET)
            AUTO_BAUD_OVERFLOW_FLAG <= 1'b1;
         else if (OVERFLOW_FLAG_CLR)
            AUTO_BAUD_OVERFLOW_FLAG <= 1'b0;
      end
   end

   // =====================================================================
   // receive complete flag, shared with the normal receiver
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         RECEIVE_COMPLETE_FLAG <= 1'b0;
      end else if (CLK_EN) begin
         // set at fifth edge; read clears, set wins
         if ((state == UABD_COUNT && rise && edges == `UABD_EDGE_LAST - 3'h1)
             || RECEIVE_FRAME_DONE)
            RECEIVE_COMPLETE_FLAG <= 1'b1;
         else if (RECEIVE_DATA_READ)
            RECEIVE_COMPLETE_FLAG <= 1'b0;
      end
   end

   // =====================================================================
   // checks
   // no parity logic exists; ninth bit handled outside
   chk_done_clears_en: assert property (@(posedge CORE_CLK) disable iff (RST)
      CLK_EN && state == UABD_COUNT && rise && edges == 3'h4
      |=> !AUTO_BAUD_ENABLE && RECEIVE_COMPLETE_FLAG)
      else $error("enable not cleared at fifth edge");
   chk_rollover_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
      CLK_EN && step && div == 16'hFFFF |=> AUTO_BAUD_OVERFLOW_FLAG && div == 16'h0000)
      else $error("rollover not trapped");
   chk_rollover_stays: assert property (@(posedge CORE_CLK) disable iff (RST)
      CLK_EN && step && div == 16'hFFFF && !rise && !AUTO_BAUD_ENABLE_CLR
      |=> AUTO_BAUD_ENABLE && state == UABD_COUNT)
      else $error("detection left on rollover");
   chk_arm_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
      CLK_EN && state == UABD_IDLE && armed_ok |=> div == 16'h0000)
      else $error("counter not cleared on enable");
   chk_sync_blocks: assert property (@(posedge CORE_CLK) disable iff (RST)
      SYNC_MODE && state == UABD_IDLE |=> state == UABD_IDLE)
      else $error("detection started in sync mode");
   chk_count_step: assert property (@(posedge CORE_CLK) disable iff (RST)
      CLK_EN && state != UABD_COUNT && !DIVISOR_WRITE && !(state == UABD_IDLE)
      |=> $stable(div))
      else $error("counter moved outside measurement");
   chk_read_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
      CLK_EN && RECEIVE_DATA_READ && !RECEIVE_FRAME_DONE && state != UABD_COUNT
      |=> !RECEIVE_COMPLETE_FLAG)
      else $error("read did not clear flag");
   chk_hold_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
      state == UABD_COUNT |-> RECEIVER_HOLD_IDLE && TRANSMIT_BLOCKED)
      else $error("receiver not held");
   cov_measure: cover property (@(posedge CORE_CLK) disable iff (RST)
      state == UABD_COUNT ##1 state == UABD_IDLE);
   cov_overflow: cover property (@(posedge CORE_CLK) disable iff (RST)
      $rose(AUTO_BAUD_OVERFLOW_FLAG));
   cov_break: cover property (@(posedge CORE_CLK) disable iff (RST)
      state == UABD_BREAK ##1 state == UABD_ARM);
endmodule : uabd_top
